// >>> design/credit_pkg.sv
// constants, policy and request-kind codes for the completion credit manager
// assumes one user clock shared with the endpoint core's transaction interface
package credit_pkg;

  // admission policies, one-hot
  typedef enum logic [4:0] {
    outstanding_cap_policy    = 5'h01,
    per_packet_credit_policy  = 5'h02,
    per_boundary_credit_policy = 5'h04,
    per_block_credit_policy   = 5'h08,
    line_rate_drain_policy    = 5'h10
  } policy_t;

  // kinds of non-posted request, one-hot
  typedef enum logic [2:0] {
    kind_mem_read = 3'h1,
    kind_io_read  = 3'h2,
    kind_io_write = 3'h4
  } req_kind_t;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned SIZE_W = 13;
  localparam int unsigned CALC_W = 14;
  localparam int unsigned HDR_W = 8;
  localparam int unsigned DATA_W = 14;

  // completion header capacity of the receive buffer in the default configuration
  localparam logic [HDR_W-1:0] HDR_CAP_DEFAULT = 8'h24;
  localparam logic [DATA_W-1:0] DATA_CAP_DEFAULT = 14'h004d;

  // read size limit: 128 bytes at field 000b, doubling to 4096 at 101b
  localparam logic [3:0] MRRS_BASE_LG = 4'h7;
  localparam logic [2:0] MRRS_FIELD_MAX = 3'h5;
  localparam logic [2:0] MRRS_FIELD_DEFAULT = 3'h0;
  // completion boundary: 64 bytes at 0, 128 bytes at 1
  localparam logic [3:0] RCB_LG_LOW = 4'h6;
  localparam logic [3:0] RCB_LG_HIGH = 4'h7;
  localparam logic RCB_SEL_DEFAULT = 1'b0;
  // one data credit covers 16 bytes
  localparam logic [3:0] CREDIT_LG = 4'h4;

  localparam logic [HDR_W-1:0] HDR_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 14'h0000;

  // ceiling(num / 2**lg)
  function automatic logic [CALC_W-1:0] ceil_pow2(input logic [CALC_W-1:0] num, input logic [3:0] lg);
    logic [CALC_W-1:0] mask;
    mask = (14'h0001 << lg) - 14'h0001;
    return (num + mask) >> lg;
  endfunction : ceil_pow2

  // low bits of an address below a power-of-two block
  function automatic logic [CALC_W-1:0] mod_pow2(input logic [ADDR_W-1:0] addr, input logic [3:0] lg);
    logic [CALC_W-1:0] mask;
    mask = (14'h0001 << lg) - 14'h0001;
    return {2'b00, addr} & mask;
  endfunction : mod_pow2

endpackage : credit_pkg

// >>> design/tag_record_mem.sv
// per-tag record of the credits reserved by each outstanding request
// written on admission, read when a completion header for that tag arrives
module tag_record_mem #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned WIDTH = 25
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // write side
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side, data one cycle after the address
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // array itself is not reset; a tag is always written before it is read
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : tag_record_mem

// >>> design/completion_credit_manager.sv
// completion credit manager: admits non-posted requests so completions never overflow the core's receive buffer
// assumes completion headers are parsed by user logic and presented as one-cycle starts on the same clock
module completion_credit_manager
  import credit_pkg::*;
#(
  parameter logic [HDR_W-1:0] HDR_CAP = HDR_CAP_DEFAULT,
  parameter logic [DATA_W-1:0] DATA_CAP = DATA_CAP_DEFAULT,
  parameter logic [1:0] DATA_SCALE_LG = 2'h0,
  parameter bit IO_SCHEME = 1'b0,
  parameter int unsigned TAG_W = 5
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // configuration from the core
  input wire policy_t policy,
  input wire logic [2:0] read_size_field,
  input wire logic rcb_sel,
  // request from the requester logic
  input wire logic req_valid,
  output logic req_ready,
  input wire req_kind_t req_kind,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [SIZE_W-1:0] req_size,
  input wire logic [TAG_W-1:0] req_tag,
  // transmit side: request goes out in the cycle both are high
  input wire logic tx_ready,
  // receive side
  input wire logic user_rx_ready,
  output logic rx_tready,
  input wire logic cpl_start,
  input wire logic [TAG_W-1:0] cpl_tag,
  input wire logic [6:0] cpl_lower_addr,
  input wire logic [SIZE_W-1:0] cpl_len_bytes,
  input wire logic cpl_final,
  // state
  output logic [CALC_W-1:0] request_ceiling,
  output logic [CALC_W-1:0] outstanding_request_count,
  output logic [HDR_W-1:0] header_credits_held,
  output logic [DATA_W-1:0] data_credits_held
);

  localparam int unsigned REC_W = HDR_W + DATA_W + 3;

  logic [3:0] mrrs_lg;
  logic [3:0] rcb_lg;
  logic [3:0] unit_lg;
  logic [DATA_W-1:0] data_credit_capacity;
  logic [CALC_W-1:0] ceil_hdr;
  logic [CALC_W-1:0] ceil_data;
  logic [CALC_W-1:0] request_header_need;
  logic [CALC_W-1:0] request_data_need;
  logic [CALC_W-1:0] data_credits_per_boundary;
  logic admit;
  logic grant;
  logic credit_mode;

  // configuration decode
  always_comb begin
    // reserved field values are clamped to 4096 bytes
    mrrs_lg = MRRS_BASE_LG + {1'b0, (read_size_field > MRRS_FIELD_MAX) ? MRRS_FIELD_MAX : read_size_field};
    rcb_lg = rcb_sel ? RCB_LG_HIGH : RCB_LG_LOW;
    unit_lg = CREDIT_LG - {2'b00, DATA_SCALE_LG};
    data_credit_capacity = DATA_CAP << DATA_SCALE_LG;
    data_credits_per_boundary = 14'h0001 << (rcb_lg - unit_lg);
    // headers per largest read is a power of two, so the floor is a shift
    ceil_hdr = {6'h00, HDR_CAP} >> (mrrs_lg - rcb_lg);
    ceil_data = data_credit_capacity >> (mrrs_lg - unit_lg);
    request_ceiling = (ceil_hdr < ceil_data) ? ceil_hdr : ceil_data;
  end

  // needs of the request on offer
  always_comb begin
    request_header_need = ceil_pow2(mod_pow2(req_addr, rcb_lg) + {1'b0, req_size}, rcb_lg);
    request_data_need = ceil_pow2(mod_pow2(req_addr, unit_lg) + {1'b0, req_size}, unit_lg);
    if (req_kind == kind_io_write) begin
      request_data_need = '0;
    end
    if (policy == per_boundary_credit_policy) begin
      request_data_need = request_header_need << (rcb_lg - unit_lg);
      if (IO_SCHEME && req_kind != kind_mem_read) begin
        request_header_need = 14'h0001;
        request_data_need = (req_kind == kind_io_read) ? 14'h0001 : 14'h0000;
      end
    end
  end

  logic [CALC_W-1:0] count_q, count_d;
  logic [HDR_W-1:0] hdr_q, hdr_d;
  logic [DATA_W-1:0] data_q, data_d;

  assign credit_mode = (policy == per_packet_credit_policy) || (policy == per_boundary_credit_policy) ||
                       (policy == per_block_credit_policy);

  // admission
  always_comb begin
    case (policy)
      outstanding_cap_policy: admit = count_q < request_ceiling;
      per_packet_credit_policy, per_boundary_credit_policy, per_block_credit_policy:
        admit = ({6'h00, hdr_q} + request_header_need <= {6'h00, HDR_CAP}) &&
                (data_q + request_data_need <= data_credit_capacity);
      // receive ready held high keeps the core's completion space from overflowing
      line_rate_drain_policy: admit = user_rx_ready;
      default: admit = 1'b0;
    endcase
  end

  assign req_ready = admit && tx_ready;
  assign grant = req_valid && req_ready;
  assign rx_tready = user_rx_ready;

  // completion stage 1: crossings from header fields, record lookup by tag
  logic cpl_v_q, cpl_v_d;
  logic final_q, final_d;
  logic [CALC_W-1:0] bnd_cross_q, bnd_cross_d;
  logic [CALC_W-1:0] blk_cross_q, blk_cross_d;
  logic [REC_W-1:0] rec_rd;
  logic [HDR_W-1:0] rec_hdr;
  logic [DATA_W-1:0] rec_data;
  logic [2:0] rec_kind;

  always_comb begin
    logic [CALC_W-1:0] nb;
    nb = '0;
    cpl_v_d = cpl_start;
    final_d = cpl_start && cpl_final;
    // a zero-length completion still frees its own header
    nb = ceil_pow2(mod_pow2({5'h00, cpl_lower_addr}, rcb_lg) + {1'b0, cpl_len_bytes}, rcb_lg);
    bnd_cross_d = (nb == '0) ? 14'h0001 : nb;
    blk_cross_d = ceil_pow2(mod_pow2({5'h00, cpl_lower_addr}, unit_lg) + {1'b0, cpl_len_bytes}, unit_lg);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cpl_v_q <= 1'b0;
      final_q <= 1'b0;
      bnd_cross_q <= '0;
      blk_cross_q <= '0;
    end else begin
      cpl_v_q <= cpl_v_d;
      final_q <= final_d;
      bnd_cross_q <= bnd_cross_d;
      blk_cross_q <= blk_cross_d;
    end
  end

  tag_record_mem #(
    .DEPTH(1 << TAG_W),
    .WIDTH(REC_W)
  ) u_records (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(grant),
    .wr_addr(req_tag),
    .wr_data({request_header_need[HDR_W-1:0], request_data_need[DATA_W-1:0], req_kind}),
    .rd_addr(cpl_tag),
    .rd_data(rec_rd)
  );

  assign {rec_hdr, rec_data, rec_kind} = rec_rd;

  // stage 2: release amounts, clamped to what is held
  logic [CALC_W-1:0] rel_h;
  logic [CALC_W-1:0] rel_d;
  logic cnt_rel;

  always_comb begin
    rel_h = '0;
    rel_d = '0;
    cnt_rel = 1'b0;
    case (policy)
      outstanding_cap_policy: cnt_rel = final_q && count_q != '0;
      per_packet_credit_policy: begin
        if (final_q) begin
          rel_h = {6'h00, rec_hdr};
          rel_d = rec_data;
        end
      end
      per_boundary_credit_policy: begin
        if (IO_SCHEME && cpl_v_q && rec_kind != kind_mem_read) begin
          rel_h = final_q ? {6'h00, rec_hdr} : 14'h0000;
          rel_d = final_q ? rec_data : 14'h0000;
        end else if (cpl_v_q) begin
          rel_h = bnd_cross_q;
          rel_d = CALC_W'(bnd_cross_q * data_credits_per_boundary);
        end
      end
      per_block_credit_policy: begin
        if (cpl_v_q) begin
          rel_h = bnd_cross_q;
          rel_d = blk_cross_q;
        end
      end
      line_rate_drain_policy: cnt_rel = 1'b0;
      default: cnt_rel = 1'b0;
    endcase
    if (rel_h > {6'h00, hdr_q}) begin
      rel_h = {6'h00, hdr_q};
    end
    if (rel_d > data_q) begin
      rel_d = data_q;
    end
  end

  // held counters
  always_comb begin
    count_d = count_q;
    hdr_d = hdr_q;
    data_d = data_q;
    if (policy == outstanding_cap_policy) begin
      count_d = count_q + CALC_W'(grant) - CALC_W'(cnt_rel);
    end
    if (credit_mode) begin
      hdr_d = HDR_W'({6'h00, hdr_q} + (grant ? request_header_need : 14'h0000) - rel_h);
      data_d = data_q + (grant ? request_data_need : 14'h0000) - rel_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_q <= '0;
      hdr_q <= HDR_RESET;
      data_q <= DATA_RESET;
    end else begin
      count_q <= count_d;
      hdr_q <= hdr_d;
      data_q <= data_d;
    end
  end

  assign outstanding_request_count = count_q;
  assign header_credits_held = hdr_q;
  assign data_credits_held = data_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_cap_grant;
    policy == outstanding_cap_policy && grant && !cnt_rel;
  endsequence

  sequence s_cap_final;
    policy == outstanding_cap_policy && cpl_start && cpl_final;
  endsequence

  sequence s_cap_quiet;
    !grant && $stable(policy) && count_q != '0;
  endsequence

  sequence s_block_start;
    policy == per_block_credit_policy && cpl_start && !grant;
  endsequence

  sequence s_block_quiet;
    !grant && $stable(policy) && data_q >= blk_cross_q;
  endsequence

  // boundary releases are checked only where every tag takes the crossing path
  sequence s_bnd_start;
    policy == per_boundary_credit_policy && !IO_SCHEME && cpl_start && !grant;
  endsequence

  sequence s_bnd_quiet;
    !grant && $stable(policy) && {6'h00, hdr_q} >= bnd_cross_q;
  endsequence

  a_count_in_range: assert property (policy == outstanding_cap_policy |-> count_q <= request_ceiling)
    else $error("outstanding count above ceiling");
  a_cap_grant_step: assert property (s_cap_grant ##0 $stable(policy) |=> count_q == $past(count_q) + 14'h0001)
    else $error("outstanding count did not step on request");
  a_ceiling_min: assert property (request_ceiling <= ceil_hdr && request_ceiling <= ceil_data)
    else $error("ceiling not the smaller floor");
  a_grant_fits: assert property (credit_mode && grant |->
                                 {6'h00, hdr_q} + request_header_need <= {6'h00, HDR_CAP} &&
                                 data_q + request_data_need <= data_credit_capacity)
    else $error("request admitted without room");
  a_held_in_cap: assert property (credit_mode |-> hdr_q <= HDR_CAP && data_q <= data_credit_capacity)
    else $error("held credits above capacity");
  a_io_write_zero: assert property (grant && req_kind == kind_io_write && policy != per_boundary_credit_policy
                                    |-> request_data_need == 14'h0000)
    else $error("io write reserved data credits");
  a_boundary_ratio: assert property (grant && policy == per_boundary_credit_policy && req_kind == kind_mem_read
                                     |-> request_data_need == (request_header_need << (rcb_lg - unit_lg)))
    else $error("boundary data need not header need times ratio");
  a_line_rate_hold: assert property (policy == line_rate_drain_policy && grant |-> user_rx_ready && rx_tready)
    else $error("request sent without receive ready");
  a_cap_release: assert property (s_cap_final ##1 s_cap_quiet |=> count_q == $past(count_q) - 14'h0001)
    else $error("outstanding count did not fall on final completion");
  a_block_release: assert property (s_block_start ##1 s_block_quiet
                                    |=> data_q == $past(data_q) - $past(blk_cross_q))
    else $error("block release amount wrong");
  a_boundary_release: assert property (s_bnd_start ##1 s_bnd_quiet
                                       |=> {6'h00, hdr_q} == $past(hdr_q) - $past(bnd_cross_q))
    else $error("boundary header release wrong");

endmodule : completion_credit_manager

// >>> verif/endpoint_core_model.sv
// behavioural stand-in for the endpoint core: transmit readiness and receive completion space
// assumes the bench presents completion starts on the same clock the core would
module endpoint_core_model #(
  parameter int unsigned HDR_SPACE = 36
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // behaviour select
  input wire logic slow,
  // receive side
  input wire logic cpl_start,
  input wire logic rx_tready,
  // transmit side and status
  output logic tx_ready,
  output logic overflow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] held_q;
  logic [7:0] held_d;
  logic phase_q;
  // slow mode offers the transmit slot every other cycle
  assign tx_ready = !slow || phase_q;
  // completion headers sit in the buffer until the user drains them
  always_comb begin
    held_d = held_q + {7'h00, cpl_start} - {7'h00, rx_tready && held_q != 8'h00};
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      held_q <= 8'h00;
      phase_q <= 1'b0;
      overflow <= 1'b0;
    end else begin
      held_q <= held_d;
      phase_q <= !phase_q;
      if (held_q > 8'(HDR_SPACE)) begin
        overflow <= 1'b1;
      end
    end
  end
endmodule : endpoint_core_model

// >>> verif/test_completion_credit_manager.sv
// self-checking bench for the completion credit manager
// assumes default capacities (36 headers, 77 data credits) and 16-byte data units
module test_completion_credit_manager
  import credit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, req_valid, req_ready, rcb_sel, tx_ready, user_rx_ready, rx_tready;
  logic cpl_start, cpl_final, slow, overflow;
  policy_t policy;
  req_kind_t req_kind;
  logic [2:0] rsf;
  logic [ADDR_W-1:0] req_addr;
  logic [SIZE_W-1:0] req_size, cpl_len;
  logic [4:0] req_tag, cpl_tag;
  logic [6:0] cpl_la;
  logic [CALC_W-1:0] ceil_v, cnt;
  logic [HDR_W-1:0] hdr;
  logic [DATA_W-1:0] dat;
  logic [HDR_W-1:0] hdr_io;
  logic [DATA_W-1:0] dat_io;
  int err_count = 0;
  int n_checks = 0;
  completion_credit_manager dut (.sys_clk(sys_clk), .rst(rst), .policy(policy), .read_size_field(rsf),
    .rcb_sel(rcb_sel), .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr),
    .req_size(req_size), .req_tag(req_tag), .tx_ready(tx_ready), .user_rx_ready(user_rx_ready),
    .rx_tready(rx_tready), .cpl_start(cpl_start), .cpl_tag(cpl_tag), .cpl_lower_addr(cpl_la),
    .cpl_len_bytes(cpl_len), .cpl_final(cpl_final), .request_ceiling(ceil_v),
    .outstanding_request_count(cnt), .header_credits_held(hdr), .data_credits_held(dat));
  endpoint_core_model core (.sys_clk(sys_clk), .rst(rst), .slow(slow), .cpl_start(cpl_start),
    .rx_tready(rx_tready), .tx_ready(tx_ready), .overflow(overflow));
  // second manager runs the I/O reservation scheme with doubleword data units
  // its data capacity only grows, so it admits whenever dut does and both stay in step
  completion_credit_manager #(.DATA_SCALE_LG(2'h2), .IO_SCHEME(1'b1)) dut_io (.sys_clk(sys_clk), .rst(rst),
    .policy(policy), .read_size_field(rsf), .rcb_sel(rcb_sel), .req_valid(req_valid), .req_ready(),
    .req_kind(req_kind), .req_addr(req_addr), .req_size(req_size), .req_tag(req_tag), .tx_ready(tx_ready),
    .user_rx_ready(user_rx_ready), .rx_tready(), .cpl_start(cpl_start), .cpl_tag(cpl_tag),
    .cpl_lower_addr(cpl_la), .cpl_len_bytes(cpl_len), .cpl_final(cpl_final), .request_ceiling(),
    .outstanding_request_count(), .header_credits_held(hdr_io), .data_credits_held(dat_io));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = !sys_clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic check_cred(input logic [7:0] h, input logic [13:0] d);
    check("header_credits_held", 16'(h), 16'(hdr));
    check("data_credits_held", 16'(d), 16'(dat));
  endtask : check_cred
  // policy may only change while idle, so every scenario starts from reset
  task automatic do_reset(input policy_t p, input logic [2:0] f, input logic s);
    @(posedge sys_clk);
    #1;
    rst = 1'b1;
    policy = p;
    rsf = f;
    rcb_sel = s;
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 1'b0;
  endtask : do_reset
  task automatic send_req(input req_kind_t k, input logic [11:0] a, input logic [12:0] sz, input logic [4:0] t);
    int i;
    // one edge between requests so valid is never lowered and raised in one step
    @(posedge sys_clk);
    #1;
    req_valid = 1'b1;
    req_kind = k;
    req_addr = a;
    req_size = sz;
    req_tag = t;
    @(negedge sys_clk);
    for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge sys_clk);
    if (i == 50) begin
      err_count++;
      $display("BAD req_ready expected 1 seen %b", req_ready);
      end_sim();
    end
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
  endtask : send_req
  task automatic probe(input req_kind_t k, input logic [12:0] sz, input logic exp);
    @(posedge sys_clk);
    #1;
    req_valid = 1'b1;
    req_kind = k;
    req_addr = 12'h000;
    req_size = sz;
    @(negedge sys_clk);
    check("req_ready", 16'(exp), 16'(req_ready));
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
  endtask : probe
  task automatic send_cpl(input logic [4:0] t, input logic [6:0] la, input logic [12:0] len, input logic fin);
    cpl_start = 1'b1;
    cpl_tag = t;
    cpl_la = la;
    cpl_len = len;
    cpl_final = fin;
    @(posedge sys_clk);
    #1;
    cpl_start = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : send_cpl
  task automatic sc_cap();
    logic [5:0] tbl [4] = '{{3'h0, 1'b0, 2'h0}, {3'h2, 1'b1, 2'h1}, {3'h1, 1'b0, 2'h2}, {3'h7, 1'b1, 2'h3}};
    logic [15:0] exp_c [4] = '{16'h9, 16'h2, 16'h4, 16'h0};
    do_reset(outstanding_cap_policy, 3'h0, 1'b0);
    check("outstanding_request_count", 16'h0, 16'(cnt));
    for (int i = 0; i < 4; i++) begin
      rsf = tbl[i][5:3];
      rcb_sel = tbl[i][2];
      @(negedge sys_clk);
      check("request_ceiling", exp_c[tbl[i][1:0]], 16'(ceil_v));
      @(posedge sys_clk);
      #1;
    end
    rsf = 3'h0;
    rcb_sel = 1'b0;
    for (int i = 0; i < 9; i++) send_req(kind_mem_read, 12'h000, 13'h0080, 5'(i));
    check("outstanding_request_count", 16'h9, 16'(cnt));
    probe(kind_mem_read, 13'h0004, 1'b0);
    send_cpl(5'h0, 7'h00, 13'h0040, 1'b0);
    check("outstanding_request_count", 16'h9, 16'(cnt));
    send_cpl(5'h0, 7'h40, 13'h0040, 1'b1);
    check("outstanding_request_count", 16'h8, 16'(cnt));
  endtask : sc_cap
  task automatic sc_packet();
    do_reset(per_packet_credit_policy, 3'h0, 1'b0);
    slow = 1'b1;
    check_cred(8'h00, 14'h0000);
    send_req(kind_mem_read, 12'h07c, 13'h0008, 5'h3);
    check_cred(8'h02, 14'h0002);
    send_req(kind_io_write, 12'h000, 13'h0004, 5'h4);
    check_cred(8'h03, 14'h0002);
    send_cpl(5'h3, 7'h7c, 13'h0004, 1'b0);
    check_cred(8'h03, 14'h0002);
    send_cpl(5'h3, 7'h00, 13'h0004, 1'b1);
    check_cred(8'h01, 14'h0000);
    slow = 1'b0;
    fork
      send_cpl(5'h4, 7'h00, 13'h0000, 1'b1);
      send_req(kind_mem_read, 12'h000, 13'h0010, 5'h5);
    join
    check_cred(8'h01, 14'h0001);
  endtask : sc_packet
  task automatic sc_boundary();
    do_reset(per_boundary_credit_policy, 3'h0, 1'b0);
    send_req(kind_mem_read, 12'h000, 13'h0080, 5'h1);
    check_cred(8'h02, 14'h0008);
    check("scaled data_credits_held", 16'h0020, 16'(dat_io));
    send_cpl(5'h1, 7'h00, 13'h0040, 1'b0);
    check_cred(8'h01, 14'h0004);
    check("scaled data_credits_held", 16'h0010, 16'(dat_io));
    send_req(kind_io_read, 12'h000, 13'h0004, 5'h6);
    check_cred(8'h02, 14'h0008);
    check("io data_credits_held", 16'h0011, 16'(dat_io));
    send_cpl(5'h6, 7'h00, 13'h0004, 1'b1);
    check_cred(8'h01, 14'h0004);
    check("io header_credits_held", 16'h0001, 16'(hdr_io));
    check("io data_credits_held", 16'h0010, 16'(dat_io));
    send_cpl(5'h1, 7'h40, 13'h0040, 1'b1);
    check_cred(8'h00, 14'h0000);
  endtask : sc_boundary
  task automatic sc_block();
    do_reset(per_block_credit_policy, 3'h0, 1'b0);
    probe(kind_mem_read, 13'h1000, 1'b0);
    send_req(kind_mem_read, 12'h000, 13'h0040, 5'h2);
    check_cred(8'h01, 14'h0004);
    send_cpl(5'h2, 7'h00, 13'h0020, 1'b0);
    check_cred(8'h00, 14'h0002);
  endtask : sc_block
  task automatic sc_line_rate();
    do_reset(line_rate_drain_policy, 3'h0, 1'b0);
    user_rx_ready = 1'b0;
    probe(kind_mem_read, 13'h1000, 1'b0);
    check("rx_tready", 16'h0, 16'(rx_tready));
    user_rx_ready = 1'b1;
    probe(kind_mem_read, 13'h1000, 1'b1);
    check("rx_tready", 16'h1, 16'(rx_tready));
  endtask : sc_line_rate
  initial begin
    {rst, req_valid, rcb_sel, cpl_start, cpl_final, slow} = 6'h20;
    user_rx_ready = 1'b1;
    policy = outstanding_cap_policy;
    req_kind = kind_mem_read;
    {rsf, req_addr, req_size, req_tag, cpl_tag, cpl_la, cpl_len} = '0;
    sc_cap();
    sc_packet();
    sc_boundary();
    sc_block();
    sc_line_rate();
    check("overflow", 16'h0, 16'(overflow));
    end_sim();
  end
endmodule : test_completion_credit_manager
